/* File: hdl/lcd_timing_pkg.sv */
// Purpose: Shared constants and types for the sync-mode and line-timing block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Reset values and field positions are kept here, except the method and calibration run bit resets and the porch and mode fields.
package lcd_timing_pkg;

    // Register byte offsets.
    localparam logic [7:0] RGB_CONTROL_OFS   = 8'h00;
    localparam logic [7:0] BACK_PORCH_OFS    = 8'h04;
    localparam logic [7:0] LINE_MODE_OFS     = 8'h08;
    localparam logic [7:0] CALIBRATION_OFS   = 8'h0C;
    localparam logic [7:0] LINE_CLOCK_OFS    = 8'h10;
    localparam logic [7:0] CONTROL_TWO_OFS   = 8'h14;
    localparam logic [7:0] WIN_MIN_X_OFS     = 8'h18;
    localparam logic [7:0] WIN_MAX_X_OFS     = 8'h1C;
    localparam logic [7:0] WIN_MIN_Y_OFS     = 8'h20;
    localparam logic [7:0] WIN_MAX_Y_OFS     = 8'h24;
    localparam logic [7:0] STATUS_OFS        = 8'h28;

    // Field positions.
    localparam int CAPTURE_BIT     = 0;
    localparam int SYNC_SEL_BIT    = 1;
    localparam int SOURCE_SEL_BIT  = 2;
    localparam int WIN_REFRESH_BIT = 3;
    localparam int BUS_SHARE_BIT   = 4;
    localparam int METHOD_BIT      = 0;
    localparam int CAL_RUN_BIT     = 0;
    localparam int CAL_DOUBLE_BIT  = 1;
    localparam int GATE_240_BIT    = 2;

    // Values after reset.
    localparam logic [7:0] RGB_CONTROL_RST = 8'h00;
    localparam logic [7:0] BACK_PORCH_RST  = 8'h00;
    localparam logic [7:0] CONTROL_TWO_RST = 8'h00;
    localparam logic [7:0] LINE_CLOCK_RST  = 8'h25;
    localparam logic [7:0] WIN_MIN_RST     = 8'h00;
    localparam logic [7:0] WIN_MAX_X_RST   = 8'hAF;
    localparam logic [7:0] WIN_MAX_Y_RST   = 8'hEF;

    // Gate line counts per frame, the dummy line comes on top.
    localparam logic [8:0] GATE_LINES_220 = 9'h0DC;
    localparam logic [8:0] GATE_LINES_240 = 9'h0F0;

    // Pixel width of the display memory.
    localparam int PIXEL_W = 18;

    typedef struct packed {
        logic                 we;
        logic [7:0]           x;
        logic [7:0]           y;
        logic [PIXEL_W-1:0]   data;
    } ram_write_t;

    typedef enum logic {CAL_IDLE, CAL_COUNT} cal_state_t;

endpackage : lcd_timing_pkg

/* File: hdl/rgb_sync_mode_line_timing.sv */
// Purpose: Mode selection, RGB capture into display memory, and line timing.
// Assumes: Sync, dot clock and panel system clock are asynchronous pins.
// Notes:   Display memory itself sits outside; this block drives its write port.
// What this block does
// - Mode 011: capture and display on external sync.
// - Mode 001: capture on external while window refresh is enabled, display internal.
// - Mode x00: host writes only, internal display.
// - Mode x10: host writes, external sync display.
// - Capture writes only inside the access window.
// - Back porch register sets external blanking.
// - New mode applies only at frame boundary.
// - Window refresh enable rewrites window internally.
// - Internal line period counts system clock edges.
// - Method bit picks calibrated or programmed count.
// - Writing calibration bit zero starts counting.
// - Count edges until bit one, then store.
// - Double select stores twice the count.
// - Line is count plus one; frame gates plus one.
// - Programmed count needs method bit, else calibrated count (25H after reset).
// - Capture samples RGB bus or shared data bus.
// - Window corners come from min and max registers.
`timescale 1ns/1ps
module rgb_sync_mode_line_timing
    import lcd_timing_pkg::*;
#(
    parameter int CAL_W = 10
) (
    input  wire logic               MCLK,
    input  wire logic               SRST,
    input  wire logic [7:0]         PADDR,
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [31:0]        PWDATA,
    output logic      [31:0]        PRDATA,
    output logic                    PREADY,
    output logic                    PSLVERR,
    input  wire logic               VSYNC,
    input  wire logic               HSYNC,
    input  wire logic               DOTCLK,
    input  wire logic               PANEL_SYSTEM_CLOCK_PIN,
    input  wire logic [PIXEL_W-1:0] PIX_DATA,
    input  wire logic [PIXEL_W-1:0] SHARED_DATA,
    input  wire logic               HOST_WE,
    input  wire logic [7:0]         HOST_X,
    input  wire logic [7:0]         HOST_Y,
    input  wire logic [PIXEL_W-1:0] HOST_DATA,
    output ram_write_t              RAM_WR,
    output logic                    LINE_START,
    output logic                    FRAME_START,
    output logic                    DISP_BLANK
);

    // The calibration counter must at least hold a full 8-bit line count.
    if (CAL_W < 9 || CAL_W > 16) begin : g_bad_cal_w
        $error("CAL_W must lie between 9 and 16");
    end

    // Pin synchronisers: three stages, a change counts once stages 1 and 2
    // agree. Index 0 vsync, 1 hsync, 2 dot clock, 3 panel system clock.
    logic [3:0] pin_in;
    logic [3:0] pin_rise;
    assign pin_in = {PANEL_SYSTEM_CLOCK_PIN, DOTCLK, HSYNC, VSYNC};

    for (genvar i = 0; i < 4; i++) begin : g_sync
        logic [2:0] chain_reg;
        logic       stable_reg;
        // Stage 0 feeds only stage 1; the filter looks at stages 1 and 2.
        always_ff @(posedge MCLK) begin
            if (SRST) begin
                chain_reg  <= 3'h0;
                stable_reg <= 1'h0;
            end else begin
                chain_reg <= {chain_reg[1:0], pin_in[i]};
                if (chain_reg[1] == chain_reg[2]) begin
                    stable_reg <= chain_reg[2];
                end
            end
        end
        assign pin_rise[i] = (chain_reg[1] == chain_reg[2]) && chain_reg[2]
                             && !stable_reg;
    end

    logic vs_rise;
    logic hs_rise;
    logic dot_rise;
    logic sys_rise;
    assign vs_rise  = pin_rise[0];
    assign hs_rise  = pin_rise[1];
    assign dot_rise = pin_rise[2];
    assign sys_rise = pin_rise[3];

    // Software registers.
    logic [7:0]       rgb_control_reg;
    logic [7:0]       back_porch_reg;
    logic             line_period_method_reg;
    logic             calibration_run_bit_reg;
    logic [7:0]       line_clock_count_reg;
    logic [7:0]       cal_count_reg;
    logic [7:0]       control_two_reg;
    logic [7:0]       win_min_x_reg;
    logic [7:0]       win_max_x_reg;
    logic [7:0]       win_min_y_reg;
    logic [7:0]       win_max_y_reg;
    logic [2:0]       active_mode_reg;
    logic [31:0]      prdata_reg;
    cal_state_t       cal_state_reg;
    logic [CAL_W-1:0] cal_cnt_reg;

    // APB decode; the slave never stalls, unmapped addresses raise pslverr.
    logic wr_en;
    logic sel_rgb;
    logic sel_bp;
    logic sel_mode;
    logic sel_cal;
    logic sel_lclk;
    logic sel_ctl2;
    logic sel_minx;
    logic sel_maxx;
    logic sel_miny;
    logic sel_maxy;
    logic sel_stat;
    logic mapped;
    assign wr_en    = PSEL && PENABLE && PWRITE;
    assign sel_rgb  = PADDR == RGB_CONTROL_OFS;
    assign sel_bp   = PADDR == BACK_PORCH_OFS;
    assign sel_mode = PADDR == LINE_MODE_OFS;
    assign sel_cal  = PADDR == CALIBRATION_OFS;
    assign sel_lclk = PADDR == LINE_CLOCK_OFS;
    assign sel_ctl2 = PADDR == CONTROL_TWO_OFS;
    assign sel_minx = PADDR == WIN_MIN_X_OFS;
    assign sel_maxx = PADDR == WIN_MAX_X_OFS;
    assign sel_miny = PADDR == WIN_MIN_Y_OFS;
    assign sel_maxy = PADDR == WIN_MAX_Y_OFS;
    assign sel_stat = PADDR == STATUS_OFS;
    assign mapped   = sel_rgb | sel_bp | sel_mode | sel_cal | sel_lclk
                    | sel_ctl2 | sel_minx | sel_maxx | sel_miny | sel_maxy
                    | sel_stat;
    assign PREADY   = 1'h1;
    assign PSLVERR  = PSEL && PENABLE && !mapped;
    assign PRDATA   = prdata_reg;

    // Calibration start and stop come straight from the bus write.
    logic       cal_start;
    logic       cal_stop;
    logic [CAL_W:0] cal_scaled;
    logic [7:0] cal_result;
    assign cal_start  = wr_en && sel_cal && !PWDATA[CAL_RUN_BIT];
    assign cal_stop   = wr_en && sel_cal && PWDATA[CAL_RUN_BIT];
    assign cal_scaled = control_two_reg[CAL_DOUBLE_BIT]
                      ? {cal_cnt_reg, 1'h0} : {1'h0, cal_cnt_reg};
    // Counts beyond eight bits saturate rather than wrap to a short line.
    assign cal_result = (|cal_scaled[CAL_W:8]) ? 8'hFF : cal_scaled[7:0];

    // Status word: active mode, calibration busy, blanking.
    logic [31:0] status_word;
    logic [31:0] rd_mux;
    assign status_word = {27'h0, DISP_BLANK, cal_state_reg == CAL_COUNT,
                          active_mode_reg};
    assign rd_mux = sel_rgb  ? {24'h0, rgb_control_reg}
                  : sel_bp   ? {24'h0, back_porch_reg}
                  : sel_mode ? {31'h0, line_period_method_reg}
                  : sel_cal  ? {31'h0, calibration_run_bit_reg}
                  : sel_lclk ? {24'h0, line_clock_count_reg}
                  : sel_ctl2 ? {24'h0, control_two_reg}
                  : sel_minx ? {24'h0, win_min_x_reg}
                  : sel_maxx ? {24'h0, win_max_x_reg}
                  : sel_miny ? {24'h0, win_min_y_reg}
                  : sel_maxy ? {24'h0, win_max_y_reg}
                  : sel_stat ? status_word
                  : 32'h0;

    // Read data is latched in the setup phase and stands through the access.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            prdata_reg <= 32'h0;
        end else if (PSEL && !PENABLE) begin
            prdata_reg <= rd_mux;
        end
    end

    // Plain control registers written from the bus.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rgb_control_reg        <= RGB_CONTROL_RST;
            back_porch_reg         <= BACK_PORCH_RST;
            line_period_method_reg <= 1'h0;
            control_two_reg        <= CONTROL_TWO_RST;
            win_min_x_reg          <= WIN_MIN_RST;
            win_max_x_reg          <= WIN_MAX_X_RST;
            win_min_y_reg          <= WIN_MIN_RST;
            win_max_y_reg          <= WIN_MAX_Y_RST;
        end else if (wr_en) begin
            if (sel_rgb)  rgb_control_reg        <= PWDATA[7:0];
            if (sel_bp)   back_porch_reg         <= PWDATA[7:0];
            if (sel_mode) line_period_method_reg <= PWDATA[METHOD_BIT];
            if (sel_ctl2) control_two_reg        <= PWDATA[7:0];
            if (sel_minx) win_min_x_reg          <= PWDATA[7:0];
            if (sel_maxx) win_max_x_reg          <= PWDATA[7:0];
            if (sel_miny) win_min_y_reg          <= PWDATA[7:0];
            if (sel_maxy) win_max_y_reg          <= PWDATA[7:0];
        end
    end

    // Calibration: counts panel clock edges from the first one after the
    // start write until the stop write, then stores the result.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            cal_state_reg           <= CAL_IDLE;
            cal_cnt_reg             <= '0;
            calibration_run_bit_reg <= 1'h1;
        end else begin
            if (cal_start || cal_stop) begin
                calibration_run_bit_reg <= PWDATA[CAL_RUN_BIT];
            end
            case (cal_state_reg)
                CAL_IDLE: begin
                    if (cal_start) begin
                        cal_state_reg <= CAL_COUNT;
                        cal_cnt_reg   <= '0;
                    end
                end
                CAL_COUNT: begin
                    if (cal_stop) begin
                        cal_state_reg <= CAL_IDLE;
                    end else if (cal_start) begin
                        cal_cnt_reg <= '0;
                    end else if (sys_rise && !(&cal_cnt_reg)) begin
                        cal_cnt_reg <= cal_cnt_reg + 1'h1;
                    end
                end
                default: cal_state_reg <= CAL_IDLE;
            endcase
        end
    end

    // Line clock count: software writes it, a finished calibration loads it.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            line_clock_count_reg <= LINE_CLOCK_RST;
            cal_count_reg        <= LINE_CLOCK_RST;
        end else if (cal_state_reg == CAL_COUNT && cal_stop) begin
            line_clock_count_reg <= cal_result;
            cal_count_reg        <= cal_result;
        end else if (wr_en && sel_lclk) begin
            line_clock_count_reg <= PWDATA[7:0];
        end
    end

    // Internal line timing from panel clock edges, not from hsync.
    // The count is taken at each line end, so a count written below the
    // running position cannot stretch the current line to a counter wrap.
    logic [8:0] ih_cnt_reg;
    logic [8:0] iv_cnt_reg;
    logic [7:0] lcount_line_reg;
    logic [7:0] lcount_sel;
    logic [8:0] gates_sel;
    logic       int_line_tick;
    logic       int_frame_tick;
    assign lcount_sel = line_period_method_reg ? line_clock_count_reg
                                               : cal_count_reg;
    assign gates_sel  = control_two_reg[GATE_240_BIT] ? GATE_LINES_240
                                                      : GATE_LINES_220;
    assign int_line_tick  = sys_rise
                         && ih_cnt_reg == {1'h0, lcount_line_reg};
    assign int_frame_tick = int_line_tick && iv_cnt_reg == gates_sel;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ih_cnt_reg      <= 9'h000;
            iv_cnt_reg      <= 9'h000;
            lcount_line_reg <= LINE_CLOCK_RST;
        end else if (int_line_tick) begin
            ih_cnt_reg      <= 9'h000;
            iv_cnt_reg      <= int_frame_tick ? 9'h000 : iv_cnt_reg + 9'h001;
            lcount_line_reg <= lcount_sel;
        end else if (sys_rise) begin
            ih_cnt_reg <= ih_cnt_reg + 9'h001;
        end
    end

    // External timing: lines since vsync, dots since hsync.
    logic [8:0] ev_line_reg;
    logic [8:0] ed_dot_reg;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ev_line_reg <= 9'h000;
            ed_dot_reg  <= 9'h000;
        end else begin
            if (vs_rise) begin
                ev_line_reg <= 9'h000;
            end else if (hs_rise && !(&ev_line_reg)) begin
                ev_line_reg <= ev_line_reg + 9'h001;
            end
            if (hs_rise || vs_rise) begin
                ed_dot_reg <= 9'h000;
            end else if (dot_rise && !(&ed_dot_reg)) begin
                ed_dot_reg <= ed_dot_reg + 9'h001;
            end
        end
    end

    // Blanking and active position from the back porch fields.
    logic [8:0] hbp;
    logic [8:0] vbp;
    logic       ext_blank;
    logic [8:0] px_full;
    logic [8:0] py_full;
    assign hbp       = {5'h00, back_porch_reg[7:4]};
    assign vbp       = {5'h00, back_porch_reg[3:0]};
    assign ext_blank = ev_line_reg <= vbp || ed_dot_reg < hbp;
    assign px_full   = ed_dot_reg - hbp;
    assign py_full   = ev_line_reg - vbp - 9'h001;

    // Mode decode; the active code only follows the register per frame.
    logic sync_ext;
    logic capture_on;
    logic line_tick;
    logic frame_tick;
    assign sync_ext   = active_mode_reg[SYNC_SEL_BIT];
    // Internal-display capture runs only while window refresh is enabled.
    assign capture_on = active_mode_reg[CAPTURE_BIT]
                      && (sync_ext || rgb_control_reg[WIN_REFRESH_BIT]);
    assign line_tick  = sync_ext ? hs_rise : int_line_tick;
    assign frame_tick = sync_ext ? vs_rise : int_frame_tick;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            active_mode_reg <= 3'h0;
        end else if (frame_tick) begin
            active_mode_reg <= rgb_control_reg[2:0];
        end
    end

    // Pixel bus: shared or dedicated, delayed to match the sync path.
    // The host must keep the dot clock running while capture is active.
    logic [PIXEL_W-1:0] pix_d1_reg;
    logic [PIXEL_W-1:0] pix_d2_reg;
    logic [PIXEL_W-1:0] pix_d3_reg;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            pix_d1_reg <= '0;
            pix_d2_reg <= '0;
            pix_d3_reg <= '0;
        end else begin
            pix_d1_reg <= rgb_control_reg[BUS_SHARE_BIT] ? SHARED_DATA
                                                         : PIX_DATA;
            pix_d2_reg <= pix_d1_reg;
            pix_d3_reg <= pix_d2_reg;
        end
    end

    // Capture write on each dot edge in the active area inside the window.
    logic in_window;
    logic cap_wr;
    logic host_wr;
    ram_write_t ram_wr_next;
    ram_write_t ram_wr_reg;
    assign in_window = !ext_blank
                     && px_full[7:0] >= win_min_x_reg && px_full[7:0] <= win_max_x_reg
                     && py_full[7:0] >= win_min_y_reg && py_full[7:0] <= win_max_y_reg
                     && !px_full[8] && !py_full[8];
    assign cap_wr  = capture_on && dot_rise && in_window;
    // Host writes are taken only while capture is off in the active mode.
    assign host_wr = !active_mode_reg[CAPTURE_BIT] && HOST_WE;
    assign ram_wr_next = cap_wr  ? '{1'h1, px_full[7:0], py_full[7:0],
                                     pix_d3_reg}
                       : host_wr ? '{1'h1, HOST_X, HOST_Y, HOST_DATA}
                       : '{1'h0, 8'h00, 8'h00, {PIXEL_W{1'h0}}};

    // Output registers.
    logic line_start_reg;
    logic frame_start_reg;
    logic blank_reg;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ram_wr_reg      <= '0;
            line_start_reg  <= 1'h0;
            frame_start_reg <= 1'h0;
            blank_reg       <= 1'h1;
        end else begin
            ram_wr_reg      <= ram_wr_next;
            line_start_reg  <= line_tick;
            frame_start_reg <= frame_tick;
            blank_reg       <= sync_ext ? ext_blank
                                        : iv_cnt_reg == gates_sel;
        end
    end
    assign RAM_WR      = ram_wr_reg;
    assign LINE_START  = line_start_reg;
    assign FRAME_START = frame_start_reg;
    assign DISP_BLANK  = blank_reg;

    // Checks.
    sequence s_cal_stop;
        cal_state_reg == CAL_COUNT && cal_stop;
    endsequence

    sequence s_cal_begin;
        cal_start && cal_state_reg == CAL_IDLE;
    endsequence

    a_mode_frame_only: assert property (@(posedge MCLK) disable iff (SRST)
        active_mode_reg != $past(active_mode_reg) |-> $past(frame_tick))
        else $error("mode changed outside a frame boundary");

    a_host_blocked_capture: assert property (@(posedge MCLK) disable iff (SRST)
        active_mode_reg[CAPTURE_BIT] && !cap_wr |=> !RAM_WR.we)
        else $error("write seen in capture mode without a capture pixel");

    a_capture_in_window: assert property (@(posedge MCLK) disable iff (SRST)
        cap_wr |=> RAM_WR.x >= win_min_x_reg && RAM_WR.x <= win_max_x_reg
                && RAM_WR.y >= win_min_y_reg && RAM_WR.y <= win_max_y_reg)
        else $error("capture write outside the window");

    a_line_length: assert property (@(posedge MCLK) disable iff (SRST)
        int_line_tick |-> ih_cnt_reg == {1'h0, lcount_line_reg}
        ##1 lcount_line_reg == $past(lcount_sel))
        else $error("internal line ended at the wrong count");

    a_default_count: assert property (@(posedge MCLK) disable iff (SRST)
        !line_period_method_reg |-> lcount_sel == cal_count_reg)
        else $error("programmed count used without method bit");

    a_cal_begin: assert property (@(posedge MCLK) disable iff (SRST)
        s_cal_begin |=> cal_state_reg == CAL_COUNT && cal_cnt_reg == '0)
        else $error("calibration did not start from zero");

    a_cal_store: assert property (@(posedge MCLK) disable iff (SRST)
        s_cal_stop |=> line_clock_count_reg == $past(cal_result)
                    && cal_state_reg == CAL_IDLE)
        else $error("calibration result not stored");

    a_cal_double: assert property (@(posedge MCLK) disable iff (SRST)
        s_cal_stop ##0 control_two_reg[CAL_DOUBLE_BIT] && cal_cnt_reg < 10'h07F
        |=> line_clock_count_reg == {$past(cal_cnt_reg[6:0]), 1'h0})
        else $error("doubled calibration count wrong");

    a_ext_line_start: assert property (@(posedge MCLK) disable iff (SRST)
        sync_ext && hs_rise |=> LINE_START ##1 !LINE_START)
        else $error("line start missing after hsync");

    a_porch_blank: assert property (@(posedge MCLK) disable iff (SRST)
        sync_ext && ed_dot_reg < hbp && !frame_tick |=> DISP_BLANK)
        else $error("not blanked inside horizontal back porch");

endmodule : rgb_sync_mode_line_timing

/* File: verif/rgb_source_model.sv */
// Purpose: Graphics controller model driving sync and pixel pins.
// Assumes: Dot clock period of 32 MCLK cycles, 160 ns.
// Notes:   Pins stand still between frames.
`timescale 1ns/1ps
module rgb_source_model
    import lcd_timing_pkg::*;
(
    input  wire logic         clk,
    output logic              vsync,
    output logic              hsync,
    output logic              dotclk,
    output logic [PIXEL_W-1:0] pix
);
    // Idle levels from time zero.
    initial begin
        {vsync, hsync, dotclk, pix} = '0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    // Every dot carries fresh data, line l dot d gets base+16l+d.
    task automatic frame(input int lines, input int dots,
                         input logic [PIXEL_W-1:0] base);
        vsync <= 1'b1;
        wt(16);
        vsync <= 1'b0;
        for (int l = 0; l < lines; l++) begin
            wt(16);
            hsync <= 1'b1;
            wt(16);
            hsync <= 1'b0;
            for (int d = 0; d < dots; d++) begin
                pix <= base + PIXEL_W'(l * 16 + d);
                wt(16);
                dotclk <= 1'b1;
                wt(16);
                dotclk <= 1'b0;
            end
        end
        wt(16);
        // Released bus shows inverted data so stale values never match.
        pix <= ~pix;
    endtask : frame
endmodule : rgb_source_model

/* File: verif/rgb_sync_mode_line_timing_tb.sv */
// Purpose: Self-checking bench for mode, capture and line timing.
// Assumes: Panel clock period of 8 MCLK cycles.
// Notes:   Line lengths are measured in MCLK cycles.
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
    mismatches++; $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module rgb_sync_mode_line_timing_tb;
    import lcd_timing_pkg::*;
    logic        MCLK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic        HOST_WE = 0, PANEL_SYSTEM_CLOCK_PIN = 0, pclk_en = 0, err;
    logic [7:0]  PADDR = 0, HOST_X = 0, HOST_Y = 0;
    logic [31:0] PWDATA = 0, PRDATA, rd;
    logic [17:0] HOST_DATA = 0, SHARED_DATA = 18'h2AAAA, PIX_DATA;
    logic        PREADY, PSLVERR, VSYNC, HSYNC, DOTCLK;
    logic        LINE_START, FRAME_START, DISP_BLANK;
    logic [2:0]  pc = 0;
    ram_write_t  RAM_WR, first_wr;
    int          mismatches = 0, tests_run = 0, wr_cnt = 0, n;
    int          fs_cnt = 0, ls_cnt = 0;
    logic        ls_blank, wr_blank;
    rgb_sync_mode_line_timing i_dut (.MCLK, .SRST, .PADDR, .PSEL, .PENABLE,
        .PWRITE, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .VSYNC, .HSYNC,
        .DOTCLK, .PANEL_SYSTEM_CLOCK_PIN, .PIX_DATA, .SHARED_DATA,
        .HOST_WE, .HOST_X, .HOST_Y, .HOST_DATA, .RAM_WR, .LINE_START,
        .FRAME_START, .DISP_BLANK);
    rgb_source_model i_src (.clk(MCLK), .vsync(VSYNC), .hsync(HSYNC),
        .dotclk(DOTCLK), .pix(PIX_DATA));
    // Clock and gated panel clock; restarting from zero keeps counts exact.
    initial forever #2.5 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        pc <= pclk_en ? pc + 3'd1 : 3'd0;
        if (pclk_en) PANEL_SYSTEM_CLOCK_PIN <= pc[2];
    end
    // Counts writes, frame and line starts; keeps blanking at the first write and the first line start.
    always @(posedge MCLK) begin
        if (RAM_WR.we === 1'b1) begin
            if (wr_cnt == 0) first_wr = RAM_WR;
            if (wr_cnt == 0) wr_blank = DISP_BLANK;
            wr_cnt++;
        end
        if (FRAME_START === 1'b1) fs_cnt++;
        if (LINE_START === 1'b1) begin
            if (ls_cnt == 0) ls_blank = DISP_BLANK;
            ls_cnt++;
        end
    end
    // A hang ends the run as a failure.
    initial begin
        repeat (60000) @(posedge MCLK);
        mismatches++;
        final_report();
    end
    task automatic final_report;
        if (mismatches == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    // One APB transfer with an idle cycle in front.
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PADDR <= a;
        PWRITE <= w;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do @(posedge MCLK);
        while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    // Third line-start interval, after any mixed line has passed.
    task automatic line_len;
        for (int p = 0; p < 3; p++) begin
            n = 0;
            do begin @(posedge MCLK); n++; end
            while (LINE_START !== 1'b1 && n < 1000);
        end
    endtask : line_len
    task automatic t_lines;
        pclk_en <= 1'b1;
        apb(1, LINE_CLOCK_OFS, 3);
        line_len();
        `CHK("line calibrated", 304, n)
        apb(1, LINE_MODE_OFS, 1);
        line_len();
        `CHK("line programmed", 32, n)
    endtask : t_lines
    task automatic t_cal(input logic dbl, input int exp);
        pclk_en <= 1'b0;
        apb(1, CONTROL_TWO_OFS, {dbl, 1'b0});
        apb(1, CALIBRATION_OFS, 0);
        pclk_en <= 1'b1;
        repeat (40) @(posedge MCLK);
        pclk_en <= 1'b0;
        repeat (10) @(posedge MCLK);
        apb(1, CALIBRATION_OFS, 1);
        apb(0, LINE_CLOCK_OFS, 0);
        `CHK("cal count", exp, rd)
    endtask : t_cal
    // A host write in capture mode must not reach memory.
    task automatic t_frame(input logic [7:0] porch, input logic [17:0] d);
        apb(1, BACK_PORCH_OFS, porch);
        wr_cnt = 0;
        fs_cnt = 0;
        ls_cnt = 0;
        HOST_WE <= 1'b1;
        @(posedge MCLK);
        HOST_WE <= 1'b0;
        i_src.frame(2, 3, 18'h01000);
        `CHK("capture count", 2, wr_cnt)
        `CHK("capture first", {1'b1, 16'h0, d}, first_wr)
        `CHK("active not blank", 1'b0, wr_blank)
        `CHK("first line blank", 1'b1, ls_blank)
        `CHK("frame starts", 1, fs_cnt)
    endtask : t_frame
    // Mode change at a frame end, then one host pulse and one frame.
    task automatic t_mode(input logic [7:0] code, input int exp);
        apb(1, RGB_CONTROL_OFS, code);
        n = 0;
        do begin apb(0, STATUS_OFS, 0); n++; end
        while (rd[2:0] !== code[2:0] && n < 3000);
        `CHK("new mode", code[2:0], rd[2:0])
        wr_cnt = 0;
        HOST_WE <= 1'b1;
        @(posedge MCLK);
        HOST_WE <= 1'b0;
        i_src.frame(2, 3, 18'h02000);
        `CHK("mode writes", exp, wr_cnt)
    endtask : t_mode
    initial begin
        repeat (5) @(posedge MCLK);
        SRST <= 1'b0;
        apb(0, LINE_CLOCK_OFS, 0);
        `CHK("line clock reset", 32'h25, rd)
        apb(0, WIN_MAX_Y_OFS, 0);
        `CHK("max y reset", 32'hEF, rd)
        apb(0, 8'h3C, 0);
        `CHK("unmapped", 1'b1, err)
        t_lines();
        HOST_WE <= 1'b1;
        HOST_X <= 8'h05;
        HOST_Y <= 8'h07;
        HOST_DATA <= 18'h01234;
        @(posedge MCLK);
        HOST_WE <= 1'b0;
        #1 `CHK("host write", {1'b1, 16'h0507, 18'h01234}, RAM_WR)
        t_cal(1'b0, 5);
        t_cal(1'b1, 10);
        pclk_en <= 1'b1;
        apb(1, LINE_CLOCK_OFS, 1);
        apb(1, WIN_MAX_X_OFS, 1);
        apb(1, WIN_MAX_Y_OFS, 0);
        apb(1, RGB_CONTROL_OFS, 3);
        apb(0, STATUS_OFS, 0);
        `CHK("mode held", 3'b000, rd[2:0])
        n = 0;
        do begin apb(0, STATUS_OFS, 0); n++; end
        while (rd[2:0] !== 3'b011 && n < 3000);
        `CHK("mode applied", 3'b011, rd[2:0])
        t_frame(8'h00, 18'h01000);
        t_frame(8'h11, 18'h01011);
        // Capture is cleared first; the host then writes outside the window.
        apb(1, RGB_CONTROL_OFS, 0);
        i_src.frame(0, 0, 18'h0);
        t_mode(8'h00, 1);
        t_mode(8'h09, 2);
        t_mode(8'h02, 1);
        final_report();
    end
endmodule : rgb_sync_mode_line_timing_tb
